// ### rtl/bpc_top.sv
// tester control: registers, routing, patterns, errors
//
// What this block and its host do
// RULE1 - rx route: off, slots, frame, illegal
// RULE2 - transmit route 01 replaces active slot bits
// RULE3 - transmit route 10 replaces every bit
// RULE4 - rising force_a bit restarts receive acquisition
// RULE5 - rising load bit latches and clears counts
// RULE6 - pattern select picks pattern type
// RULE7 - quasi-random forces one before fourteen zeros
// RULE8 - rx invert bit inverts incoming data
// RULE9 - tx invert bit inverts generated data
// RULE10 - repetitive length is code plus seventeen
// RULE11 - rx ignores length for pseudorandom
// RULE12 - host programs short patterns as multiples
// RULE13 - overflow interrupt when enabled
// RULE14 - bit error interrupt when enabled
// RULE15 - sync change interrupt when enabled
// RULE16 - rising pattern load bit loads generator
// RULE17 - rising single error bit corrupts one bit
// RULE18 - rate code n flips one per 10^n
// RULE19 - alternating words each sent count plus one
// RULE20 - host loads all ones for pseudorandom
// RULE21 - edges found against previous cycle value
// RULE22 - illegal codes disable the path
`timescale 1ns/1ps
`include "bpc_cfg.svh"
module bpc_top
    import bpc_pkg::*;
#(
    parameter logic [23:0] RATE_E4 = `BPC_RATE_E4,
    parameter logic [23:0] RATE_E5 = `BPC_RATE_E5,
    parameter logic [23:0] RATE_E6 = `BPC_RATE_E6,
    parameter logic [23:0] RATE_E7 = `BPC_RATE_E7
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic [15:0]      regRdData,
    // pattern words
    input  wire logic [15:0] patWordLower,
    input  wire logic [15:0] patWordUpper,
    // transmit formatter stream
    input  wire logic        txBitEn,
    input  wire logic        txSlotActive,
    input  wire logic        txDataIn,
    output logic             txDataOut,
    // receive framer stream
    input  wire logic        rxBitEn,
    input  wire logic        rxSlotActive,
    input  wire logic        rxDataIn,
    // receive checker feed
    output logic             rxTestEnable,
    output logic             rxTestStrobe,
    output logic             rxTestData,
    output logic [2:0]       rxPatternSel,
    output logic [3:0]       rxRepLenCode,
    output logic             rxResync,
    output logic             counterLoad,
    // receive checker events
    input  wire logic        bitCountOvf,
    input  wire logic        errCountOvf,
    input  wire logic        bitErrorSeen,
    input  wire logic        patternSync,
    output logic             testerIrq
);

    // control registers
    logic [15:0] route_q;
    logic [15:0] ctrl0_q;
    logic [15:0] ctrl1_q;
    logic [15:0] rdData_q;

    // edge detection history
    logic [3:0]  edgePrev_q;
    logic [3:0]  edgeCur;
    logic [3:0]  edgeRise;

    // transmit state
    logic        txOut_q;
    logic        sbePending_q;
    logic [23:0] rateCnt_q;
    logic [23:0] rateCnt_d;

    // receive state
    logic        rxEnable_q;
    logic        rxStrobe_q;
    logic        rxData_q;
    logic [2:0]  rxPatSel_q;
    logic [3:0]  rxRepLen_q;
    logic        rxResync_q;
    logic        cntLoad_q;
    logic        syncPrev_q;
    logic        irq_q;

    // decoded fields
    bpc_route_t   rxRoute;
    bpc_route_t   txRoute;
    bpc_pattern_t patSel;
    logic         rxInvert;
    logic         txInvert;
    logic [3:0]   repLenCode;
    logic [2:0]   rateCode;
    logic [7:0]   altCount;
    logic         patLegal;

    // address decode
    logic        hitRoute;
    logic        hitCtrl0;
    logic        hitCtrl1;
    logic        hitStatus;
    logic [15:0] rdMux;
    logic [15:0] statusWord;

    // datapath wires
    logic        resyncRise;
    logic        loadRise;
    logic        tcRise;
    logic        sbeRise;
    logic        txUse;
    logic        genBit;
    logic [23:0] rateDiv;
    logic        rateHit;
    logic        flipBit;
    logic        rxTake;
    logic        rxOn;
    logic        syncChange;
    logic        irqEvent;

    // register address decode
    assign hitRoute  = (regAddr == `BPC_OFS_ROUTE);
    assign hitCtrl0  = (regAddr == `BPC_OFS_CTRL0);
    assign hitCtrl1  = (regAddr == `BPC_OFS_CTRL1);
    assign hitStatus = (regAddr == `BPC_OFS_STATUS);

    // field decode
    assign rxRoute    = bpc_route_t'(route_q[`BPC_RX_ROUTE]);
    assign txRoute    = bpc_route_t'(route_q[`BPC_TX_ROUTE]);
    assign patSel     = bpc_pattern_t'(ctrl0_q[`BPC_C0_PSEL]); // RULE6
    assign rxInvert   = ctrl0_q[`BPC_C0_RXINV];
    assign txInvert   = ctrl0_q[`BPC_C0_TXINV];
    assign repLenCode = ctrl0_q[`BPC_C0_RPL];
    assign rateCode   = ctrl1_q[`BPC_C1_EIB];
    assign altCount   = ctrl1_q[`BPC_C1_AWC];

    // codes 110 and 111 leave both paths off
    assign patLegal = (patSel != BPC_PAT_BAD6) && (patSel != BPC_PAT_BAD7); // RULE22

    // block state seen by software
    assign statusWord = {11'h000, irq_q, patternSync, sbePending_q, rxEnable_q,
                         patLegal && (txRoute == BPC_ROUTE_SLOTS ||
                                      txRoute == BPC_ROUTE_FRAME)};

    // read select, unmapped reads zero
    assign rdMux = hitRoute  ? route_q :
                   hitCtrl0  ? ctrl0_q :
                   hitCtrl1  ? ctrl1_q :
                   hitStatus ? statusWord :
                               16'h0000;

    // register writes, reserved bits kept at zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            route_q <= `BPC_RST_ROUTE;
            ctrl0_q <= `BPC_RST_CTRL0;
            ctrl1_q <= `BPC_RST_CTRL1;
        end else if (regWrEn) begin
            if (hitRoute) begin
                route_q <= regWrData & `BPC_MASK_ROUTE;
            end
            if (hitCtrl0) begin
                ctrl0_q <= regWrData & `BPC_MASK_CTRL0;
            end
            if (hitCtrl1) begin
                ctrl1_q <= regWrData & `BPC_MASK_CTRL1;
            end
        end
    end

    // read data for one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdData_q <= 16'h0000;
        end else begin
            rdData_q <= regRdEn ? rdMux : 16'h0000;
        end
    end

    // edge bits against last cycle
    assign edgeCur = {ctrl1_q[`BPC_C1_SBE], ctrl1_q[`BPC_C1_TC],
                      ctrl0_q[`BPC_C0_LOAD], ctrl0_q[`BPC_C0_FORCE_A]};

    // zero-to-one changes only
    assign edgeRise = edgeCur & ~edgePrev_q; // RULE21

    // one-cycle actions
    assign resyncRise = edgeRise[0]; // RULE4
    assign loadRise   = edgeRise[1]; // RULE5
    assign tcRise     = edgeRise[2]; // RULE16
    assign sbeRise    = edgeRise[3]; // RULE17

    // history of the edge bits
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            edgePrev_q <= 4'h0;
        end else begin
            edgePrev_q <= edgeCur;
        end
    end

    // transmit slot selection
    assign txUse = txBitEn && patLegal &&
                   ((txRoute == BPC_ROUTE_SLOTS && txSlotActive) || // RULE2
                    (txRoute == BPC_ROUTE_FRAME)); // RULE3

    // pattern source
    bpc_pattern_gen u_gen (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .patternSel (patSel),
        .repLenCode (repLenCode),
        .altCount   (altCount),
        .wordLower  (patWordLower),
        .wordUpper  (patWordUpper),
        .loadPulse  (tcRise),
        .advance    (txUse),
        .genBit     (genBit)
    );

    // bits per inserted error for the rate code
    assign rateDiv = (rateCode == 3'd1) ? `BPC_RATE_E1 :
                     (rateCode == 3'd2) ? `BPC_RATE_E2 :
                     (rateCode == 3'd3) ? `BPC_RATE_E3 :
                     (rateCode == 3'd4) ? RATE_E4 :
                     (rateCode == 3'd5) ? RATE_E5 :
                     (rateCode == 3'd6) ? RATE_E6 :
                                          RATE_E7;

    // last bit of each period flips; >= recovers after a rate drop
    assign rateHit = (rateCode != 3'd0) && (rateCnt_q >= rateDiv - 24'd1); // RULE18

    // count used bits, zero while rate is off
    assign rateCnt_d = (rateCode == 3'd0) ? 24'h000000 :
                       !txUse             ? rateCnt_q :
                       rateHit            ? 24'h000000 :
                                            rateCnt_q + 24'h000001;

    // single and rate errors merge into one flip
    assign flipBit = txUse && (sbePending_q || rateHit);

    // a new single error request beats its use
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rateCnt_q    <= 24'h000000;
            sbePending_q <= 1'b0;
        end else begin
            rateCnt_q    <= rateCnt_d;
            sbePending_q <= sbeRise || (sbePending_q && !txUse); // RULE17
        end
    end

    // transmit output, bypass when tester unused
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txOut_q <= 1'b0;
        end else if (txUse) begin
            txOut_q <= genBit ^ flipBit ^ txInvert; // RULE9
        end else if (txBitEn) begin
            txOut_q <= txDataIn; // RULE22
        end
    end

    // receive feed, illegal codes give nothing
    assign rxOn = patLegal && (rxRoute == BPC_ROUTE_SLOTS ||
                               rxRoute == BPC_ROUTE_FRAME); // RULE1

    // a strobe per taken bit
    assign rxTake = rxBitEn && patLegal &&
                    ((rxRoute == BPC_ROUTE_SLOTS && rxSlotActive) ||
                     (rxRoute == BPC_ROUTE_FRAME)); // RULE1

    // receive checker feed
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rxEnable_q <= 1'b0;
            rxStrobe_q <= 1'b0;
            rxData_q   <= 1'b0;
            rxPatSel_q <= 3'b000;
            rxRepLen_q <= 4'h0;
            rxResync_q <= 1'b0;
            cntLoad_q  <= 1'b0;
        end else begin
            rxEnable_q <= rxOn;
            rxStrobe_q <= rxTake;
            if (rxTake) begin
                rxData_q <= rxDataIn ^ rxInvert; // RULE8
            end
            rxPatSel_q <= patSel;
            rxRepLen_q <= (patSel == BPC_PAT_REP) ? repLenCode : 4'h0; // RULE11
            rxResync_q <= resyncRise; // RULE4
            cntLoad_q  <= loadRise; // RULE5
        end
    end

    // interrupt from checker events
    assign syncChange = patternSync ^ syncPrev_q;

    // enabled events only
    assign irqEvent =
        (ctrl0_q[`BPC_C0_OVERFLOW_IRQ_ENABLE]   && (bitCountOvf || errCountOvf)) || // RULE13
        (ctrl0_q[`BPC_C0_BIT_ERROR_IRQ_ENABLE]  && bitErrorSeen) || // RULE14
        (ctrl0_q[`BPC_C0_SYNC_CHANGE_IRQ_ENABLE] && syncChange); // RULE15

    // sync history and interrupt output
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            syncPrev_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            syncPrev_q <= patternSync;
            irq_q      <= irqEvent;
        end
    end

    // outputs straight from flip-flops
    assign regRdData    = rdData_q;
    assign txDataOut    = txOut_q;
    assign rxTestEnable = rxEnable_q;
    assign rxTestStrobe = rxStrobe_q;
    assign rxTestData   = rxData_q;
    assign rxPatternSel = rxPatSel_q;
    assign rxRepLenCode = rxRepLen_q;
    assign rxResync     = rxResync_q;
    assign counterLoad  = cntLoad_q;
    assign testerIrq    = irq_q;

endmodule

// ### inc/bpc_cfg.svh
// offsets, fields, resets and rate counts of the tester control
`ifndef BPC_CFG_SVH
`define BPC_CFG_SVH

// register offsets
`define BPC_OFS_ROUTE   8'h20
`define BPC_OFS_CTRL0   8'h22
`define BPC_OFS_CTRL1   8'h24
`define BPC_OFS_STATUS  8'h30

// reset values
`define BPC_RST_ROUTE   16'h0000
`define BPC_RST_CTRL0   16'h0000
`define BPC_RST_CTRL1   16'h0000

// writable bits, reserved bits read zero
`define BPC_MASK_ROUTE  16'h000f
`define BPC_MASK_CTRL0  16'hef7f
`define BPC_MASK_CTRL1  16'hfff1

// route register fields
`define BPC_RX_ROUTE    1:0
`define BPC_TX_ROUTE    3:2

// primary control fields
`define BPC_C0_FORCE_A   0
`define BPC_C0_LOAD     1
`define BPC_C0_PSEL     4:2
`define BPC_C0_RXINV    5
`define BPC_C0_TXINV    6
`define BPC_C0_RPL      11:8
`define BPC_C0_OVERFLOW_IRQ_ENABLE     13
`define BPC_C0_BIT_ERROR_IRQ_ENABLE    14
`define BPC_C0_SYNC_CHANGE_IRQ_ENABLE   15

// secondary control fields
`define BPC_C1_TC       0
`define BPC_C1_SBE      4
`define BPC_C1_EIB      7:5
`define BPC_C1_AWC      15:8

// last bit index of a repetitive pattern at code zero
`define BPC_REP_LAST0   5'd16

// bits per inserted error for each rate code
`define BPC_RATE_E1     24'd10
`define BPC_RATE_E2     24'd100
`define BPC_RATE_E3     24'd1000
`define BPC_RATE_E4     24'd10000
`define BPC_RATE_E5     24'd100000
`define BPC_RATE_E6     24'd1000000
`define BPC_RATE_E7     24'd10000000

`endif

// ### inc/bpc_pkg.sv
// types of the tester control: route and pattern codes
package bpc_pkg;

    typedef enum logic [1:0] {
        BPC_ROUTE_OFF   = 2'b00,
        BPC_ROUTE_SLOTS = 2'b01,
        BPC_ROUTE_FRAME = 2'b10,
        BPC_ROUTE_BAD   = 2'b11
    } bpc_route_t;

    typedef enum logic [2:0] {
        BPC_PAT_P7   = 3'b000,
        BPC_PAT_P11  = 3'b001,
        BPC_PAT_P15  = 3'b010,
        BPC_PAT_QRS  = 3'b011,
        BPC_PAT_REP  = 3'b100,
        BPC_PAT_ALT  = 3'b101,
        BPC_PAT_BAD6 = 3'b110,
        BPC_PAT_BAD7 = 3'b111
    } bpc_pattern_t;

endpackage

// ### rtl/bpc_pattern_gen.sv
// pattern generator: pseudorandom, repetitive, alternating
`timescale 1ns/1ps
`include "bpc_cfg.svh"
module bpc_pattern_gen
    import bpc_pkg::*;
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // configuration
    input  wire bpc_pattern_t patternSel,
    input  wire logic [3:0]   repLenCode,
    input  wire logic [7:0]   altCount,
    input  wire logic [15:0]  wordLower,
    input  wire logic [15:0]  wordUpper,
    // control
    input  wire logic         loadPulse,
    input  wire logic         advance,
    // generated bit
    output logic              genBit
);

    logic [19:0] lfsr_q;
    logic [31:0] rep_q;
    logic [31:0] repNext;
    logic [3:0]  altBit_q;
    logic [7:0]  altWord_q;
    logic        altUpper_q;
    logic        feedback;
    logic [4:0]  repLast;
    logic        qrsBit;
    logic [15:0] altWord;

    // feedback taps per pseudorandom length
    assign feedback = (patternSel == BPC_PAT_P7)  ? (lfsr_q[6] ^ lfsr_q[5]) :
                      (patternSel == BPC_PAT_P11) ? (lfsr_q[10] ^ lfsr_q[8]) :
                      (patternSel == BPC_PAT_P15) ? (lfsr_q[14] ^ lfsr_q[13]) :
                                                    (lfsr_q[19] ^ lfsr_q[16]);

    // one forced before fourteen zeros
    assign qrsBit = lfsr_q[19] | (lfsr_q[18:5] == 14'h0000); // RULE7

    // repetitive rotation within the length
    assign repLast = `BPC_REP_LAST0 + {1'b0, repLenCode}; // RULE10
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_rot
            if (gi == 31) begin : g_top
                assign repNext[gi] = (repLast == 5'(gi)) ? rep_q[0] : 1'b0;
            end else begin : g_mid
                assign repNext[gi] = (repLast == 5'(gi)) ? rep_q[0] : rep_q[gi+1];
            end
        end
    endgenerate

    assign altWord = altUpper_q ? wordUpper : wordLower;

    // output select, lsb of each word sent first
    always_comb begin
        case (patternSel)
            BPC_PAT_P7:  genBit = lfsr_q[6];
            BPC_PAT_P11: genBit = lfsr_q[10];
            BPC_PAT_P15: genBit = lfsr_q[14];
            BPC_PAT_QRS: genBit = qrsBit;
            BPC_PAT_REP: genBit = rep_q[0];
            BPC_PAT_ALT: genBit = altWord[altBit_q];
            default:     genBit = 1'b0;
        endcase
    end

    // state load and advance
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lfsr_q     <= 20'h00000;
            rep_q      <= 32'h00000000;
            altBit_q   <= 4'h0;
            altWord_q  <= 8'h00;
            altUpper_q <= 1'b0;
        end else if (loadPulse) begin
            lfsr_q     <= {wordUpper[3:0], wordLower}; // RULE16
            rep_q      <= {wordUpper, wordLower};
            altBit_q   <= 4'h0;
            altWord_q  <= 8'h00;
            altUpper_q <= 1'b0;
        end else if (advance) begin
            lfsr_q   <= {lfsr_q[18:0], feedback};
            rep_q    <= repNext;
            altBit_q <= altBit_q + 4'h1;
            if (altBit_q == 4'hf) begin
                if (altWord_q == altCount) begin // RULE19
                    altWord_q  <= 8'h00;
                    altUpper_q <= ~altUpper_q;
                end else begin
                    altWord_q <= altWord_q + 8'h01;
                end
            end
        end
    end

endmodule

// ### sim/bpc_top_sva.sv
// assertion checker on the tester control ports
`timescale 1ns/1ps
`include "bpc_cfg.svh"
module bpc_top_sva (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // register writes
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWrEn,
    // streams
    input wire logic        txBitEn,
    input wire logic        txDataIn,
    input wire logic        txDataOut,
    input wire logic        rxBitEn,
    input wire logic        rxDataIn,
    input wire logic        rxTestStrobe,
    input wire logic        rxTestData,
    // events
    input wire logic        rxResync,
    input wire logic        counterLoad,
    input wire logic        bitErrorSeen,
    input wire logic        testerIrq
);
    logic [15:0] routeQ;
    logic [15:0] ctrlQ;
    logic        wrCtrl;
    logic        rsRise;
    logic        ldRise;
    logic        txOff;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // edge rises and transmit bypass
    assign wrCtrl = regWrEn && regAddr == `BPC_OFS_CTRL0;
    assign rsRise = wrCtrl && regWrData[0] && !ctrlQ[0];
    assign ldRise = wrCtrl && regWrData[1] && !ctrlQ[1];
    assign txOff  = routeQ[3:2] inside {2'b00, 2'b11} || ctrlQ[4:3] == 2'b11;

    // register shadows
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            routeQ <= 16'h0000;
            ctrlQ  <= 16'h0000;
        end else begin
            if (regWrEn && regAddr == `BPC_OFS_ROUTE) routeQ <= regWrData & `BPC_MASK_ROUTE;
            if (wrCtrl) ctrlQ <= regWrData & `BPC_MASK_CTRL0;
        end
    end

    property p_force_a; rsRise |-> ##2 rxResync ##1 !rxResync; endproperty
    a_force_a: assert property (p_force_a) else $error("no force_a pulse");
    property p_load; ldRise |-> ##2 counterLoad ##1 !counterLoad; endproperty
    a_load: assert property (p_load) else $error("no load pulse");
    property p_rs_cause; rxResync |-> $past(rsRise, 2); endproperty
    a_rs_cause: assert property (p_rs_cause) else $error("force_a without rise");
    property p_rx_strobe; rxTestStrobe |-> $past(rxBitEn); endproperty
    a_rx_strobe: assert property (p_rx_strobe) else $error("strobe without bit");
    property p_rx_data;
        rxTestStrobe |-> rxTestData == ($past(rxDataIn) ^ $past(ctrlQ[5]));
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("rx data wrong");
    property p_tx_pass; txBitEn && txOff |=> txDataOut == $past(txDataIn); endproperty
    a_tx_pass: assert property (p_tx_pass) else $error("bypass data altered");
    property p_irq_bed; bitErrorSeen && ctrlQ[14] |=> testerIrq; endproperty
    a_irq_bed: assert property (p_irq_bed) else $error("no error irq");
    property p_irq_mask; testerIrq |-> $past(ctrlQ[15:13]) != 3'b000; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
endmodule

bind bpc_top bpc_top_sva u_sva (.*);

// ### sim/bpc_frame_model.sv
// stream source: a bit per clock, slot 0 of eight is overhead
`timescale 1ns/1ps
module bpc_frame_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // stream enable
    input  wire logic run,
    // bit slots
    output logic      bitEn,
    output logic      slotActive,
    output logic      bitData
);
    logic [3:0] slotQ;

    // idle line toggles so no stale bit looks valid
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            slotQ      <= 4'h0;
            bitEn      <= 1'b0;
            slotActive <= 1'b0;
            bitData    <= 1'b0;
        end else begin
            bitEn      <= run;
            slotActive <= run && slotQ[2:0] != 3'h0;
            bitData    <= run ? slotQ[3] ^ slotQ[0] ^ slotQ[1] : ~bitData;
            if (run) slotQ <= slotQ + 4'h1;
        end
    end
endmodule

// ### sim/tb_bpc_top.sv
// self-checking bench for the tester control block
`timescale 1ns/1ps
`include "bpc_cfg.svh"
module tb_bpc_top
    import bpc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [15:0] regRdData;
    logic        run = 1'b0;
    logic        bitEn, slotActive, bitData, rxTestEnable;
    logic [2:0]  rxPatternSel, ev = 3'h0;
    logic        patternSync = 1'b0;
    logic        txDataOut, rxTestStrobe, rxTestData, rxResync, counterLoad, testerIrq;
    logic [3:0]  rxRepLenCode;
    logic [15:0] cfgRt, cfgC0;
    logic [15:0] patWord = 16'hffff;
    int          errCount = 0;
    int          checks = 0;
    int          cycles = 0;

    // short rate counts
    bpc_top #(.RATE_E4(24'd40), .RATE_E5(24'd50), .RATE_E6(24'd60), .RATE_E7(24'd70)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .patWordLower(patWord), .patWordUpper(patWord),
        .txBitEn(bitEn), .txSlotActive(slotActive), .txDataIn(bitData), .txDataOut(txDataOut),
        .rxBitEn(bitEn), .rxSlotActive(slotActive), .rxDataIn(bitData),
        .rxTestEnable(rxTestEnable), .rxTestStrobe(rxTestStrobe), .rxTestData(rxTestData),
        .rxPatternSel(rxPatternSel), .rxRepLenCode(rxRepLenCode), .rxResync(rxResync),
        .counterLoad(counterLoad), .bitCountOvf(ev[0]), .errCountOvf(ev[1]),
        .bitErrorSeen(ev[2]), .patternSync(patternSync), .testerIrq(testerIrq));

    // stream source
    bpc_frame_model u_frame (.clk_sys(clk_sys), .sys_rst(sys_rst), .run(run),
        .bitEn(bitEn), .slotActive(slotActive), .bitData(bitData));

    // clock and hang guard
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (++cycles == 10000) begin
            errCount++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        chk("read data", e, regRdData);
    endtask

    // route, control, pattern load
    task automatic cfg(input logic [15:0] rt, input logic [15:0] c0);
        cfgRt = rt;
        cfgC0 = c0;
        wr(`BPC_OFS_ROUTE, rt);
        wr(`BPC_OFS_CTRL0, c0);
        wr(`BPC_OFS_CTRL1, 16'h0000);
        wr(`BPC_OFS_CTRL1, 16'h0001);
    endtask

    // watch n bits; zero words give generated 0
    task automatic stream(input int n, output int flips);
        logic en, slot, din, legal, used, took;
        int   seen = 0;
        flips = 0;
        legal = cfgC0[4:2] < 3'd6;
        while (seen < n) begin
            @(posedge clk_sys);
            en = bitEn === 1'b1;
            slot = slotActive;
            din = bitData;
            #1;
            used = legal && (cfgRt[3:2] == 2'b10 || (cfgRt[3:2] == 2'b01 && slot));
            took = en && legal && (cfgRt[1:0] == 2'b10 || (cfgRt[1:0] == 2'b01 && slot));
            if (en) begin
                seen++;
                if (!used) chk("tx bypass", din, txDataOut);
                else if (txDataOut !== cfgC0[6]) flips++;
            end
            chk("rx strobe", took, rxTestStrobe);
            chk("rx enable", legal && ^cfgRt[1:0], rxTestEnable);
            if (took) chk("rx data", din ^ cfgC0[5], rxTestData);
        end
    endtask

    task automatic count(input int k, output int n);
        n = 0;
        repeat (5) begin
            #1;
            n += (k == 2 ? testerIrq : k == 1 ? counterLoad : rxResync) === 1'b1;
            @(posedge clk_sys);
        end
    endtask

    task automatic t_regs();
        logic [7:0]  ofs [3] = '{`BPC_OFS_ROUTE, `BPC_OFS_CTRL0, `BPC_OFS_CTRL1};
        logic [15:0] msk [3] = '{`BPC_MASK_ROUTE, `BPC_MASK_CTRL0, `BPC_MASK_CTRL1};
        for (int i = 0; i < 3; i++) begin
            rd(ofs[i], 16'h0000);
            wr(ofs[i], 16'hffff);
            rd(ofs[i], msk[i]);
            wr(ofs[i], 16'h0000);
        end
        wr(8'h40, 16'hffff);
        rd(8'h40, 16'h0000);
        $display("regs done");
    endtask

    task automatic t_edges();
        int n;
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 3; k++) begin
                wr(`BPC_OFS_CTRL0, k == 0 ? 16'h0000 : 16'h0001 << b);
                count(b, n);
                chk("edge pulses", k == 1, n[15:0]);
            end
        end
        $display("edges done");
    endtask

    task automatic t_irq();
        int n;
        int ie [4] = '{13, 13, 14, 15};
        for (int e = 0; e < 4; e++) begin
            for (int on = 0; on < 2; on++) begin
                wr(`BPC_OFS_CTRL0, 16'(on) << ie[e]);
                @(posedge clk_sys);
                if (e < 3) ev[e] <= 1'b1;
                else patternSync <= ~patternSync;
                @(posedge clk_sys);
                ev <= 3'h0;
                count(2, n);
                chk("irq pulses", on, n[15:0]);
            end
        end
        $display("irq done");
    endtask

    task automatic t_len();
        logic [15:0] c [3] = '{16'h0010, 16'h0f10, 16'h0f00};
        logic [3:0]  x [3] = '{4'h0, 4'hf, 4'h0};
        for (int i = 0; i < 3; i++) begin
            wr(`BPC_OFS_CTRL0, c[i]);
            repeat (2) @(posedge clk_sys);
            #1;
            chk("length code", x[i], rxRepLenCode);
            chk("pattern copy", c[i][4:2], rxPatternSel);
        end
        $display("len done");
    endtask

    task automatic t_path();
        int f;
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 8; r++) begin
                cfg({12'h000, r[1:0], r[1:0]},
                    {9'h000, r[2], r[2], p ? BPC_PAT_BAD6 : BPC_PAT_REP, 2'b00});
                stream(24, f);
                chk("tx flips", 16'h0000, f[15:0]);
            end
        end
        $display("path done");
    endtask

    task automatic t_err();
        int f;
        int code [7] = '{1, 4, 5, 6, 7, 2, 3};
        cfg(16'h000a, {11'h000, BPC_PAT_REP, 2'b00});
        wr(`BPC_OFS_CTRL1, 16'h0011);
        stream(24, f);
        chk("single error", 16'h0001, f[15:0]);
        wr(`BPC_OFS_CTRL1, 16'h0011);
        stream(24, f);
        chk("held error bit", 16'h0000, f[15:0]);
        for (int i = 0; i < 7; i++) begin
            wr(`BPC_OFS_CTRL1, {8'h00, code[i][2:0], 5'h01});
            stream(code[i] < 4 ? 2 * 10 ** code[i] : 20 * code[i], f);
            chk("rate errors", 16'h0002, f[15:0]);
        end
        $display("errors done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // reset, then scenarios
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        run <= 1'b1;
        t_regs();
        t_edges();
        t_irq();
        t_len();
        patWord <= 16'h0000;
        t_path();
        t_err();
        test_done();
    end
endmodule
